// ===== lxar_front_model.sv
`timescale 1ns/1ps
// Behavioural front end: converts a light level at the scale the block asks for.
module lxar_front_model (
    input  wire logic [3:0]  convActiveScale,
    input  wire logic        convActive,
    input  wire logic [31:0] lightLevel,
    output logic      [19:0] linearFraction,
    output logic             adcOverflow
);
    logic [31:0] scaled;

    assign scaled = lightLevel >> convActiveScale;

    // Outside a conversion the fraction lines carry the inverse of the scaled sample, never the sample itself,
    // so a block that samples at the wrong moment reports a wrong value instead of a lucky one.
    always_comb begin
        adcOverflow    = convActive && (scaled > 32'h000F_FFFF);
        linearFraction = convActive ? scaled[19:0] : ~scaled[19:0];
    end
endmodule

// ===== lxar_pkg.sv
package lxar_pkg;

    localparam int unsigned CLK_FREQ_MHZ = 10;
    localparam int unsigned NUM_CONV     = 12;

    typedef int unsigned lxar_tab_t [NUM_CONV];

    // Conversion periods in microseconds, indexed by the period code.
    localparam lxar_tab_t CONV_TIME_US = '{
        600, 1000, 1800, 3400, 6500, 12700,
        25000, 50000, 100000, 200000, 400000, 800000
    };

    // Each period is microseconds times MHz; a zero product is raised so no period drops below one cycle.
    function automatic lxar_tab_t lxar_cycles(input int unsigned mhz);
        lxar_tab_t r;
        for (int i = 0; i < NUM_CONV; i++) begin
            r[i] = CONV_TIME_US[i] * mhz;
            if (r[i] == 0) begin
                r[i] = 1;
            end
        end
        return r;
    endfunction

    localparam lxar_tab_t CONV_CYC_DEF = lxar_cycles(CLK_FREQ_MHZ);

    localparam int unsigned FRAC_W  = 20;
    localparam int unsigned UPPER_W = 12;
    localparam int unsigned LOWER_W = 8;
    localparam int unsigned SCALE_W = 4;
    localparam int unsigned LIN_W   = 28;
    localparam int unsigned TH_W    = 36;
    localparam int unsigned TIMER_W = 24;
    localparam int unsigned CNT_W   = 4;

    localparam logic [3:0] RANGE_AUTO    = 4'hC;
    localparam logic [3:0] SCALE_MAX     = 4'h8;
    localparam logic [3:0] CONV_CODE_MAX = 4'hB;
    localparam logic [4:0] TH_SHIFT      = 5'h08;

    localparam logic [3:0]  SCALE_RST  = 4'h8;
    localparam logic [19:0] LOW_NEAR   = 20'h4_0000;
    localparam logic [19:0] LOW_FAR    = 20'h1_0000;
    localparam logic [19:0] HIGH_NEAR  = 20'hC_0000;
    localparam logic [19:0] FRAC_FULL  = 20'hF_FFFF;

    typedef enum logic {LXAR_IDLE, LXAR_CONVERT} lxar_state_t;

endpackage

// ===== lxar_result_logic.sv
`timescale 1ns/1ps
module lxar_result_logic #(
    parameter lxar_pkg::lxar_tab_t CONV_CYC  = lxar_pkg::CONV_CYC_DEF,
    parameter logic [19:0]         LOW_NEAR  = lxar_pkg::LOW_NEAR,
    parameter logic [19:0]         LOW_FAR   = lxar_pkg::LOW_FAR,
    parameter logic [19:0]         HIGH_NEAR = lxar_pkg::HIGH_NEAR
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        measStart,
    input  wire logic [3:0]  rangeSetting,
    input  wire logic [3:0]  convTimeCode,
    input  wire logic [11:0] upperLimitValue,
    input  wire logic [3:0]  upperLimitScale,
    input  wire logic [11:0] lowerLimitValue,
    input  wire logic [3:0]  lowerLimitScale,
    input  wire logic [1:0]  faultCountSel,
    input  wire logic        latchMode,
    input  wire logic        flagClear,
    input  wire logic [19:0] linearFraction,
    input  wire logic        adcOverflow,
    output logic             convActive,
    output logic [3:0]       convScale,
    output logic [11:0]      measureUpperBits,
    output logic [7:0]       measureLowerBits,
    output logic [3:0]       measureScaleCode,
    output logic [27:0]      linearCode,
    output logic             resultValid,
    output logic             highFault,
    output logic             lowFault,
    output logic             flagHigh,
    output logic             flagLow
);

    lxar_pkg::lxar_state_t state;
    logic [23:0] timer;
    logic        useAuto;
    logic [3:0]  hiCnt;
    logic [3:0]  loCnt;

    logic        atEnd;
    logic        retry;
    logic        report;
    logic [3:0]  codeSafe;
    logic [3:0]  manualScale;
    logic [23:0] loadCount;
    logic [19:0] repFrac;
    logic [27:0] linNow;
    logic [35:0] thHigh;
    logic [35:0] thLow;
    logic        faultH;
    logic        faultL;
    logic [3:0]  need;
    logic        hitH;
    logic        hitL;
    logic [3:0]  next_autoScale;

    // Codes above the table clamp to the longest period / widest range.
    assign codeSafe = (convTimeCode > lxar_pkg::CONV_CODE_MAX) ?
                      lxar_pkg::CONV_CODE_MAX : convTimeCode;
    assign manualScale = (rangeSetting > lxar_pkg::SCALE_MAX) ?
                         lxar_pkg::SCALE_MAX : rangeSetting;
    assign loadCount = 24'(CONV_CYC[codeSafe] - 1);

    assign atEnd  = (state == lxar_pkg::LXAR_CONVERT) && (timer == '0);
    assign retry  = atEnd && useAuto && adcOverflow &&
                    (convScale != lxar_pkg::SCALE_MAX);
    assign report = atEnd && !retry;

    // A manual range that overflows still reports, pinned at full scale.
    assign repFrac = adcOverflow ? lxar_pkg::FRAC_FULL : linearFraction;
    assign linNow  = 28'({8'h00, repFrac} << convScale);
    assign thHigh  = 36'({24'h00_0000, upperLimitValue} <<
                     (lxar_pkg::TH_SHIFT + {1'b0, upperLimitScale}));
    assign thLow   = 36'({24'h00_0000, lowerLimitValue} <<
                     (lxar_pkg::TH_SHIFT + {1'b0, lowerLimitScale}));
    assign faultH  = {8'h00, linNow} > thHigh;
    assign faultL  = {8'h00, linNow} < thLow;

    assign need = 4'h1 << faultCountSel;
    assign hitH = report && faultH && ((hiCnt + 4'h1) >= need);
    assign hitL = report && faultL && ((loCnt + 4'h1) >= need);

    // Stepping saturates at both ends so a dark or bright scene cannot wrap.
    always_comb begin
        next_autoScale = convScale;
        if (adcOverflow) begin
            next_autoScale = convScale;
        end else if (linearFraction < LOW_FAR) begin
            next_autoScale = (convScale > 4'h1) ? convScale - 4'h2 : 4'h0;
        end else if (linearFraction < LOW_NEAR) begin
            next_autoScale = (convScale > 4'h0) ? convScale - 4'h1 : 4'h0;
        end else if (linearFraction > HIGH_NEAR) begin
            next_autoScale = (convScale < lxar_pkg::SCALE_MAX) ?
                             convScale + 4'h1 : lxar_pkg::SCALE_MAX;
        end
    end

    // Starts that arrive while a conversion runs are ignored.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= lxar_pkg::LXAR_IDLE;
            timer      <= '0;
            useAuto    <= 1'b0;
            convActive <= 1'b0;
        end else begin
            case (state)
                lxar_pkg::LXAR_IDLE: begin
                    if (measStart) begin
                        state      <= lxar_pkg::LXAR_CONVERT;
                        timer      <= loadCount;
                        useAuto    <= (rangeSetting == lxar_pkg::RANGE_AUTO);
                        convActive <= 1'b1;
                    end
                end
                lxar_pkg::LXAR_CONVERT: begin
                    if (timer != '0) begin
                        timer <= timer - 24'h00_0001;
                    end else if (retry) begin
                        timer <= loadCount;
                    end else begin
                        state      <= lxar_pkg::LXAR_IDLE;
                        convActive <= 1'b0;
                    end
                end
                default: begin
                    state      <= lxar_pkg::LXAR_IDLE;
                    convActive <= 1'b0;
                end
            endcase
        end
    end

    // The scale in use; in auto mode it also carries over as the next start point.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            convScale <= lxar_pkg::SCALE_RST;
        end else if (state == lxar_pkg::LXAR_IDLE && measStart &&
                     rangeSetting != lxar_pkg::RANGE_AUTO) begin
            convScale <= manualScale;
        end else if (retry) begin
            convScale <= convScale + 4'h1;
        end else if (report && useAuto) begin
            convScale <= next_autoScale;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            measureUpperBits <= '0;
            measureLowerBits <= '0;
            measureScaleCode <= '0;
            linearCode       <= '0;
            resultValid      <= 1'b0;
            highFault        <= 1'b0;
            lowFault         <= 1'b0;
        end else begin
            resultValid <= report;
            highFault   <= report && faultH;
            lowFault    <= report && faultL;
            if (report) begin
                measureUpperBits <= repFrac[19:8];
                measureLowerBits <= repFrac[7:0];
                measureScaleCode <= convScale;
                linearCode       <= linNow;
            end
        end
    end

    // Counting stops at seven, so seven plus one still meets the largest need of eight.
    // A counter that ran on to fifteen would wrap in the compare and never re-arm a flag.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hiCnt <= '0;
            loCnt <= '0;
        end else if (report) begin
            hiCnt <= !faultH ? 4'h0 : (hiCnt == 4'h7) ? hiCnt : hiCnt + 4'h1;
            loCnt <= !faultL ? 4'h0 : (loCnt == 4'h7) ? loCnt : loCnt + 4'h1;
        end
    end

    // Latched flags: a qualifying event in the clearing cycle wins over the clear.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flagHigh <= 1'b0;
            flagLow  <= 1'b0;
        end else if (latchMode) begin
            flagHigh <= hitH || (flagHigh && !flagClear);
            flagLow  <= hitL || (flagLow && !flagClear);
        end else begin
            if (hitH) begin
                flagHigh <= 1'b1;
                flagLow  <= 1'b0;
            end else if (hitL) begin
                flagHigh <= 1'b0;
                flagLow  <= 1'b1;
            end
        end
    end

    property p_start_load;
        @(posedge ref_clk) disable iff (!nrst)
        (state == lxar_pkg::LXAR_IDLE && measStart)
        |=> (timer == $past(loadCount)) && convActive;
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("Conversion timer not loaded from the period code.");

    property p_retry;
        @(posedge ref_clk) disable iff (!nrst)
        (atEnd && useAuto && adcOverflow && convScale < lxar_pkg::SCALE_MAX)
        |=> !resultValid && convActive && convScale == $past(convScale) + 4'h1;
    endproperty
    a_retry: assert property (p_retry)
        else $error("Overflow did not raise the scale and retry.");

    property p_step_up;
        @(posedge ref_clk) disable iff (!nrst)
        (report && useAuto && !adcOverflow && linearFraction > HIGH_NEAR &&
         convScale < lxar_pkg::SCALE_MAX)
        |=> convScale == $past(convScale) + 4'h1;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("Auto scale did not rise by one step.");

    property p_step_down;
        @(posedge ref_clk) disable iff (!nrst)
        (report && useAuto && !adcOverflow && linearFraction < LOW_NEAR &&
         convScale > 4'h1)
        |=> (convScale == $past(convScale) - 4'h1) ||
            (convScale == $past(convScale) - 4'h2);
    endproperty
    a_step_down: assert property (p_step_down)
        else $error("Auto scale did not fall by one or two steps.");

    property p_bounds;
        @(posedge ref_clk) disable iff (!nrst)
        convScale <= lxar_pkg::SCALE_MAX;
    endproperty
    a_bounds: assert property (p_bounds)
        else $error("Scale left the range 0 to 8.");

    property p_manual;
        @(posedge ref_clk) disable iff (!nrst)
        (state == lxar_pkg::LXAR_IDLE && measStart &&
         rangeSetting <= lxar_pkg::SCALE_MAX)
        |=> convScale == $past(rangeSetting);
    endproperty
    a_manual: assert property (p_manual)
        else $error("Manual range not applied to the conversion.");

    property p_fields;
        @(posedge ref_clk) disable iff (!nrst)
        resultValid |-> linearCode ==
            28'({8'h00, measureUpperBits, measureLowerBits} << measureScaleCode);
    endproperty
    a_fields: assert property (p_fields)
        else $error("Linear code does not match fraction and scale.");

    property p_fault_high;
        @(posedge ref_clk) disable iff (!nrst)
        report |=> highFault == ({8'h00, linearCode} > $past(thHigh));
    endproperty
    a_fault_high: assert property (p_fault_high)
        else $error("High fault event does not match the limit.");

    property p_fault_low;
        @(posedge ref_clk) disable iff (!nrst)
        report |=> lowFault == ({8'h00, linearCode} < $past(thLow));
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("Low fault event does not match the limit.");

    property p_latch_hold;
        @(posedge ref_clk) disable iff (!nrst)
        latchMode && flagHigh && !flagClear |=> flagHigh;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched high flag dropped without a clear.");

    property p_persist;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(flagHigh) |-> $past(report) && $past(faultH) &&
                            ($past(hiCnt) + 4'h1 >= $past(need));
    endproperty
    a_persist: assert property (p_persist)
        else $error("High flag set before the fault count was reached.");

    c_retry: cover property (@(posedge ref_clk) disable iff (!nrst) retry);
    c_flag_high: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(flagHigh));
    c_step_down: cover property (@(posedge ref_clk) disable iff (!nrst)
        report && useAuto && linearFraction < LOW_FAR);
    c_latch_clear: cover property (@(posedge ref_clk) disable iff (!nrst)
        latchMode && flagClear && flagHigh);

endmodule

// ===== test_light_autorange_result_logic.sv
`timescale 1ns/1ps
module test_light_autorange_result_logic;
    localparam lxar_pkg::lxar_tab_t CYC = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};
    logic        ref_clk, nrst, measStart, latchMode, flagClear;
    logic [3:0]  rangeSetting, convTimeCode, upperLimitScale, lowerLimitScale;
    logic [11:0] upperLimitValue, lowerLimitValue;
    logic [1:0]  faultCountSel;
    logic [31:0] lightLevel;
    logic [19:0] linearFraction;
    logic        adcOverflow, convActive, resultValid, highFault, lowFault;
    logic [3:0]  convScale, measureScaleCode;
    logic [11:0] measureUpperBits;
    logic [7:0]  measureLowerBits;
    logic [27:0] linearCode;
    logic        flagHigh, flagLow, gotHigh, gotLow;
    int          numErrors = 0;
    int          nCompared = 0;
    int          lat;

    lxar_result_logic #(.CONV_CYC(CYC)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .measStart(measStart),
        .rangeSetting(rangeSetting), .convTimeCode(convTimeCode),
        .upperLimitValue(upperLimitValue), .upperLimitScale(upperLimitScale),
        .lowerLimitValue(lowerLimitValue), .lowerLimitScale(lowerLimitScale),
        .faultCountSel(faultCountSel), .latchMode(latchMode), .flagClear(flagClear),
        .linearFraction(linearFraction), .adcOverflow(adcOverflow),
        .convActive(convActive), .convScale(convScale),
        .measureUpperBits(measureUpperBits), .measureLowerBits(measureLowerBits),
        .measureScaleCode(measureScaleCode), .linearCode(linearCode),
        .resultValid(resultValid), .highFault(highFault), .lowFault(lowFault),
        .flagHigh(flagHigh), .flagLow(flagLow)
    );

    lxar_front_model front_u (
        .convActiveScale(convScale), .convActive(convActive),
        .lightLevel(lightLevel), .linearFraction(linearFraction),
        .adcOverflow(adcOverflow)
    );

    task automatic chkVal(input logic [35:0] got, input logic [35:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkTime(input int got, input int exp);
        nCompared++;
        if (got != exp) begin
            numErrors++;
            $display("[FAIL] %0t latency %0d expected %0d", $time, got, exp);
        end
    endtask

    // Starts one measurement and returns just after the edge that brings its result.
    task automatic measure(input logic [3:0] rng, input logic [3:0] code, input logic [31:0] lit);
        @(negedge ref_clk);
        rangeSetting = rng;
        convTimeCode = code;
        lightLevel   = lit;
        measStart    = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        measStart = 1'b0;
        for (lat = 1; lat < 400; lat++) begin
            @(posedge ref_clk);
            #1;
            if (resultValid === 1'b1) break;
        end
        gotHigh = highFault;
        gotLow  = lowFault;
    endtask

    task automatic testAuto();
        logic [3:0] sc;
        sc = 4'h8;
        for (int k = 0; k < 5; k++) begin
            measure(4'hC, 4'h0, 32'h0000_0100);
            chkVal(36'(measureScaleCode), 36'(sc), "auto scale");
            chkVal(36'(linearCode), 36'h0_0000_0100, "auto linear");
            sc = (sc > 4'h1) ? sc - 4'h2 : 4'h0;
            chkVal(36'(convScale), 36'(sc), "step down");
        end
        measure(4'hC, 4'h0, 32'h000F_0000);
        chkVal(36'(convScale), 36'h0_0000_0001, "step up");
        // Seven overflow retries from scale 1 before scale 8 holds the light.
        measure(4'hC, 4'h1, 32'h0A00_0000);
        chkTime(lat, CYC[1] * 8);
        chkVal(36'(measureScaleCode), 36'h0_0000_0008, "retry scale");
        chkVal(36'(linearCode), 36'h0_0A00_0000, "retry linear");
        measure(4'hC, 4'h0, 32'h0FF0_0000);
        chkVal(36'(convScale), 36'h0_0000_0008, "top stays");
        measure(4'hC, 4'h0, 32'h1000_0000);
        chkTime(lat, CYC[0]);
        chkVal(36'({measureUpperBits, measureLowerBits}), 36'hF_FFFF, "top ovf");
    endtask

    task automatic testManual();
        logic [3:0] s;
        for (int i = 0; i < 12; i++) begin
            s = 4'(i % 9);
            measure(s, 4'(i), 32'h0001_2345 << s);
            chkTime(lat, CYC[i]);
            chkVal(36'(measureScaleCode), 36'(s), "manual scale");
            chkVal(36'(measureUpperBits), 36'h0_0000_0123, "upper");
            chkVal(36'(measureLowerBits), 36'h0_0000_0045, "lower");
            chkVal(36'(linearCode), 36'h0_0001_2345 << s, "linear");
        end
    endtask

    task automatic testLimits();
        // A reset in mid-run clears the flags that earlier scenarios left behind.
        @(negedge ref_clk);
        nrst = 1'b0;
        @(negedge ref_clk);
        chkVal(36'({flagHigh, flagLow, resultValid}), 36'h0, "reset flags");
        chkVal(36'(convScale), 36'h0_0000_0008, "reset scale");
        nrst = 1'b1;
        @(negedge ref_clk);
        upperLimitValue = 12'h123;
        upperLimitScale = 4'h0;
        lowerLimitValue = 12'h010;
        lowerLimitScale = 4'h1;
        faultCountSel   = 2'h1;
        // Fields read high event, low event, high flag, low flag.
        measure(4'h0, 4'h0, 32'h0001_2300);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'h0, "equal");
        measure(4'h0, 4'h0, 32'h0001_2301);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'h8, "hi 1");
        measure(4'h0, 4'h0, 32'h0001_2301);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'hA, "hi 2");
        measure(4'h0, 4'h0, 32'h0000_1FFF);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'h6, "lo 1");
        measure(4'h0, 4'h0, 32'h0000_1FFF);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'h5, "lo 2");
        // Latched window: both flags may stand together until a clear.
        @(negedge ref_clk);
        latchMode     = 1'b1;
        faultCountSel = 2'h0;
        measure(4'h0, 4'h0, 32'h0001_2301);
        chkVal(36'({gotHigh, gotLow, flagHigh, flagLow}), 36'hB, "latched");
        @(negedge ref_clk);
        flagClear = 1'b1;
        @(negedge ref_clk);
        flagClear = 1'b0;
        chkVal(36'({flagHigh, flagLow}), 36'h0, "cleared");
        // A non-fault result empties the run count before four events are needed.
        faultCountSel = 2'h2;
        measure(4'h0, 4'h0, 32'h0001_2300);
        for (int k = 0; k < 4; k++) begin
            measure(4'h0, 4'h0, 32'h0001_2301);
            chkVal(36'(flagHigh), 36'(k == 3), "count four");
        end
    endtask

    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // All scenarios need well under a thousand cycles; this allows several times that.
    initial begin
        #500_000;
        numErrors++;
        completeRun();
    end

    initial begin
        nrst            = 1'b0;
        measStart       = 1'b0;
        rangeSetting    = 4'hC;
        convTimeCode    = 4'h0;
        upperLimitValue = 12'hFFF;
        upperLimitScale = 4'h8;
        lowerLimitValue = 12'h000;
        lowerLimitScale = 4'h0;
        faultCountSel   = 2'h0;
        latchMode       = 1'b0;
        flagClear       = 1'b0;
        lightLevel      = 32'h0000_0000;
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        testAuto();
        testManual();
        testLimits();
        completeRun();
    end
endmodule
